// >>> rtl/pscr_top.sv
// Configuration bank for shared reset pin, load switch limits, power-fail cutoff and buck one
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - Select bit 7 of register 0x14 makes the shared pin an output when 0 and a warm-reset input when 1, resetting to 1.
// RULE2 - While the select bit is 1 the output level bit has no effect on the shared pin.
// RULE3 - Bit 6 of register 0x14 selects hysteresis and resets to 1 in the base variant and 0 in the 200 mV variant.
// RULE4 - Bits 3-2 hold the switch three current limit code 100/200/500/1000 mA, resetting to 00.
// RULE5 - Bits 1-0 hold the switch two current limit code with the same encoding, resetting to 00.
// RULE6 - Bits 5-3 of register 0x15 turn switches three, two, one off while power-fail is low.
// RULE7 - Bits 2-0 of register 0x15 discharge switches three, two, one while off, resetting to 0.
// RULE8 - Bit 7 of register 0x16 enables pulse-skip when 1 and forces PWM when 0, resetting to 1.
// RULE9 - The 6-bit code maps to 850 mV plus 10 mV steps to 1350 mV, then 25 mV steps to 1675 mV.
// RULE10 - Register 0x16 resets to 0x99 so the code starts at 19h, 1100 mV.
// RULE11 - Reserved bits read as zero and ignore writes.
// RULE12 - Writes are taken only after the host has unlocked them; others are refused.
module pscr_top
    import pscr_pkg::*;
#(
    parameter bit HYS200_VARIANT = 1'b0
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire pscr_req_type req,
    input wire logic gpo_level,
    input wire logic [2:0] switch_enable,
    input wire logic power_fail_out_n,
    input wire logic shared_pin_in,
    output logic shared_pin_out,
    output logic shared_pin_oe_n,
    output logic buck_warm_reset,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic write_refused,
    output logic lockout_hysteresis_select,
    output logic [1:0] switch3_current_limit,
    output logic [1:0] switch2_current_limit,
    output logic [2:0] switch_on,
    output logic [2:0] discharge_active,
    output logic pulse_skip_enable,
    output logic [5:0] buck_one_vcode,
    output logic [10:0] buck_one_mv
);
    // RULE3 variant reset value
    localparam logic [7:0] PIN_LIMIT_RST = HYS200_VARIANT ? PSCR_RST_PIN_LIMIT_HYS200 : PSCR_RST_PIN_LIMIT_BASE;

    logic rst_n;
    logic pf_n_s;
    logic pin_s;
    logic [1:0] pins_s;
    pscr_state_type s_q;
    pscr_state_type s_d;
    logic [2:0] cutoff;
    logic [5:0] code;

    // Reset released through two flops so all state leaves reset on one edge
    pscr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
        .core_clk(core_clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(rst_n)
    );

    // Pins idle high, so sync starts high to avoid a false power-fail after reset
    pscr_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({power_fail_out_n, shared_pin_in}),
        .q(pins_s)
    );
    assign pf_n_s = pins_s[1];
    assign pin_s = pins_s[0];
    assign cutoff = s_q.pf_discharge[PSCR_LSB_CUTOFF +: 3];
    assign code = s_q.buck_one[PSCR_LSB_VCODE +: 6];

    // Next state: register writes, reads and derived pin controls
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.refused = 1'b0;
        // RULE12 writes need unlock
        if (req.wr && !req.unlocked) begin
            s_d.refused = 1'b1;
        end else if (req.wr) begin
            // RULE11 reserved bits stay zero through the masks
            case (req.addr)
                PSCR_ADDR_PIN_LIMIT: begin
                    // RULE4 and RULE5 limit fields stored
                    s_d.pin_limit = req.wdata & PSCR_MASK_PIN_LIMIT;
                end
                PSCR_ADDR_PF_DISCHARGE: begin
                    s_d.pf_discharge = req.wdata & PSCR_MASK_PF_DISCHARGE;
                end
                PSCR_ADDR_BUCK_ONE: begin
                    // RULE8 mode bit stored with code
                    s_d.buck_one = req.wdata & PSCR_MASK_BUCK_ONE;
                end
                default: begin
                    s_d.refused = 1'b0;
                end
            endcase
        end
        // Reads return the stored value; unmapped subaddresses read zero
        if (req.rd) begin
            s_d.rvalid = 1'b1;
            case (req.addr)
                PSCR_ADDR_PIN_LIMIT: s_d.rdata = s_q.pin_limit;
                PSCR_ADDR_PF_DISCHARGE: s_d.rdata = s_q.pf_discharge;
                PSCR_ADDR_BUCK_ONE: s_d.rdata = s_q.buck_one;
                default: s_d.rdata = 8'h00;
            endcase
        end
        // RULE1 pin role follows select bit
        // RULE2 level bit ignored in reset-input role
        if (s_q.pin_limit[PSCR_BIT_WARM_RESET_SEL]) begin
            s_d.pin_oe_n = 1'b1;
            s_d.warm_reset = ~pin_s;
        end else begin
            s_d.pin_oe_n = gpo_level;
            s_d.warm_reset = 1'b0;
        end
        // RULE6 power-fail cutoff per switch
        s_d.switch_on = switch_enable & ~(cutoff & {3{~pf_n_s}});
        // RULE7 discharge only while switch is off
        s_d.discharge = s_q.pf_discharge[PSCR_LSB_DISCHARGE +: 3] & ~s_q.switch_on;
        // RULE9 two-slope voltage map
        if (code <= PSCR_CODE_KNEE) begin
            s_d.buck_mv = 11'(PSCR_MV_BASE + 11'(code) * PSCR_MV_FINE_STEP);
        end else begin
            s_d.buck_mv = 11'(PSCR_MV_KNEE + 11'(code - PSCR_CODE_KNEE) * PSCR_MV_COARSE_STEP);
        end
    end

    // Single state register; reset values are constants only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // RULE1 select resets to 1, RULE3 hysteresis by variant
            s_q.pin_limit <= PIN_LIMIT_RST;
            // RULE7 discharge and cutoff reset to 0
            s_q.pf_discharge <= PSCR_RST_PF_DISCHARGE;
            // RULE10 buck register reset value
            s_q.buck_one <= PSCR_RST_BUCK_ONE;
            s_q.rdata <= 8'h00;
            s_q.rvalid <= 1'b0;
            s_q.refused <= 1'b0;
            s_q.pin_oe_n <= 1'b1;
            s_q.warm_reset <= 1'b0;
            s_q.switch_on <= 3'h0;
            s_q.discharge <= 3'h0;
            s_q.buck_mv <= 11'h44c;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops, except shared_pin_out tied low
    assign shared_pin_out = 1'b0;
    assign shared_pin_oe_n = s_q.pin_oe_n;
    assign buck_warm_reset = s_q.warm_reset;
    assign rdata = s_q.rdata;
    assign rvalid = s_q.rvalid;
    assign write_refused = s_q.refused;
    assign lockout_hysteresis_select = s_q.pin_limit[PSCR_BIT_HYST_SEL];
    assign switch3_current_limit = s_q.pin_limit[PSCR_LSB_SW3_LIMIT +: 2];
    assign switch2_current_limit = s_q.pin_limit[PSCR_LSB_SW2_LIMIT +: 2];
    assign switch_on = s_q.switch_on;
    assign discharge_active = s_q.discharge;
    assign pulse_skip_enable = s_q.buck_one[PSCR_BIT_PULSE_SKIP];
    assign buck_one_vcode = code;
    assign buck_one_mv = s_q.buck_mv;

    a_pin_released: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
        s_q.pin_limit[7] |=> s_q.pin_oe_n) else $error("Shared pin driven in reset-input role");
    a_warm_reset_in: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
        (s_q.pin_limit[7] && !pin_s) |=> s_q.warm_reset) else $error("Warm reset not passed to bucks");
    a_gpo_low_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
        (!s_q.pin_limit[7] && !gpo_level) |=> (!s_q.pin_oe_n && !s_q.warm_reset)) else $error("Output low not driven");
    a_limit_write: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
        (req.wr && req.unlocked && req.addr == 8'h14) |=> (s_q.pin_limit[3:0] == $past(req.wdata[3:0])))
        else $error("Limit fields not written");
    a_pf_cutoff: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
        (cutoff[0] && !pf_n_s) |=> !s_q.switch_on[0]) else $error("Switch one on during power fail");
    a_discharge_off: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
        (s_q.pf_discharge[1] && !s_q.switch_on[1]) |=> s_q.discharge[1]) else $error("Switch two not discharged");
    a_mode_write: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE8
        (req.wr && req.unlocked && req.addr == 8'h16) |=> (pulse_skip_enable == $past(req.wdata[7])))
        else $error("Pulse-skip bit not written");
    a_knee_volts: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
        (code == 6'h32) |=> (s_q.buck_mv == 11'd1350)) else $error("Knee voltage wrong");
    a_top_volts: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
        (code == 6'h3f) |=> (s_q.buck_mv == 11'd1675)) else $error("Top voltage wrong");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
        (s_q.pin_limit[5:4] == 2'h0 && s_q.pf_discharge[7:6] == 2'h0 && !s_q.buck_one[6]))
        else $error("Reserved bit set");
    a_locked_write: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
        (req.wr && !req.unlocked) |=> (write_refused && $stable(s_q.pin_limit) && $stable(s_q.pf_discharge)
        && $stable(s_q.buck_one))) else $error("Locked write accepted");
endmodule : pscr_top
`default_nettype wire

// >>> pkg/pscr_pkg.sv
// Constants, field layout and carrier types of the switch and buck configuration bank
package pscr_pkg;
    // Register subaddresses
    localparam logic [7:0] PSCR_ADDR_PIN_LIMIT = 8'h14;
    localparam logic [7:0] PSCR_ADDR_PF_DISCHARGE = 8'h15;
    localparam logic [7:0] PSCR_ADDR_BUCK_ONE = 8'h16;

    // Reset values
    localparam logic [7:0] PSCR_RST_PIN_LIMIT_BASE = 8'hc0;
    localparam logic [7:0] PSCR_RST_PIN_LIMIT_HYS200 = 8'h80;
    localparam logic [7:0] PSCR_RST_PF_DISCHARGE = 8'h00;
    localparam logic [7:0] PSCR_RST_BUCK_ONE = 8'h99;

    // Writable bits; reserved bits are zero in each mask
    localparam logic [7:0] PSCR_MASK_PIN_LIMIT = 8'hcf;
    localparam logic [7:0] PSCR_MASK_PF_DISCHARGE = 8'h3f;
    localparam logic [7:0] PSCR_MASK_BUCK_ONE = 8'hbf;

    // Field positions
    localparam int PSCR_BIT_WARM_RESET_SEL = 7;
    localparam int PSCR_BIT_HYST_SEL = 6;
    localparam int PSCR_LSB_SW3_LIMIT = 2;
    localparam int PSCR_LSB_SW2_LIMIT = 0;
    localparam int PSCR_LSB_CUTOFF = 3;
    localparam int PSCR_LSB_DISCHARGE = 0;
    localparam int PSCR_BIT_PULSE_SKIP = 7;
    localparam int PSCR_LSB_VCODE = 0;

    // Voltage code mapping, millivolts
    localparam logic [10:0] PSCR_MV_BASE = 11'h352;
    localparam logic [10:0] PSCR_MV_KNEE = 11'h546;
    localparam logic [10:0] PSCR_MV_FINE_STEP = 11'h00a;
    localparam logic [10:0] PSCR_MV_COARSE_STEP = 11'h019;
    localparam logic [5:0] PSCR_CODE_KNEE = 6'h32;

    // Register access request from the serial bus front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic unlocked;
    } pscr_req_type;

    // Whole state of the bank
    typedef struct packed {
        logic [7:0] pin_limit;
        logic [7:0] pf_discharge;
        logic [7:0] buck_one;
        logic [7:0] rdata;
        logic rvalid;
        logic refused;
        logic pin_oe_n;
        logic warm_reset;
        logic [2:0] switch_on;
        logic [2:0] discharge;
        logic [10:0] buck_mv;
    } pscr_state_type;
endpackage : pscr_pkg

// >>> rtl/pscr_sync.sv
// Two flip-flop synchroniser, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module pscr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i] <= RESET_VAL[i];
                    q[i] <= RESET_VAL[i];
                end else begin
                    meta_q[i] <= d[i];
                    q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule : pscr_sync
`default_nettype wire

// >>> testbench/pscr_host_model.sv
// Host model issuing register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module pscr_host_model
    import pscr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rvalid,
    input wire logic write_refused,
    input wire logic [7:0] rdata,
    output var pscr_req_type req
);
    initial begin
        req = '0;
    end
    // unlock sent with write
    // Unlock rides with each write; a locked write is only sent when the caller asks for it
    task automatic write(input logic [7:0] a, input logic [7:0] v, input logic u, output logic rf);
        @(posedge core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v, unlocked: u};
        @(posedge core_clk);
        // Released lines show the inverse, not the stale value
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v, unlocked: ~u};
        #1;
        rf = write_refused;
    endtask : write
    // Answer stands right after the taking edge, so it is sampled 1 ns past that edge
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a, unlocked: 1'b0};
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5, unlocked: 1'b1};
        #1;
        ok = rvalid;
        d = rdata;
    endtask : read
endmodule : pscr_host_model
`default_nettype wire

// >>> testbench/test_pmic_switch_buck_config_regs.sv
// Self-checking bench of the switch and buck configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_pmic_switch_buck_config_regs;
    import pscr_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic gpo_level = 1'b1;
    logic [2:0] switch_enable = 3'h0;
    logic power_fail_out_n = 1'b1;
    logic shared_pin_in = 1'b1;
    pscr_req_type req;
    logic shared_pin_out, shared_pin_oe_n, buck_warm_reset, rvalid, write_refused;
    logic lockout_hysteresis_select, pulse_skip_enable, ok, rf, u;
    logic [7:0] rdata, rd, a;
    logic [1:0] switch3_current_limit, switch2_current_limit;
    logic [2:0] switch_on, discharge_active, on;
    logic [5:0] buck_one_vcode;
    logic [10:0] buck_one_mv;
    logic hys_b;
    logic [7:0] rdata_b;
    logic [31:0] r;
    logic [7:0] sh [4];
    logic [7:0] msk [4] = '{8'hcf, 8'h3f, 8'hbf, 8'h00};
    integer seed, fails, compares, i;

    pscr_top uut (.core_clk, .resetn, .req, .gpo_level, .switch_enable, .power_fail_out_n,
        .shared_pin_in, .shared_pin_out, .shared_pin_oe_n, .buck_warm_reset, .rdata, .rvalid,
        .write_refused, .lockout_hysteresis_select, .switch3_current_limit, .switch2_current_limit,
        .switch_on, .discharge_active, .pulse_skip_enable, .buck_one_vcode, .buck_one_mv);
    pscr_host_model host (.core_clk, .rvalid, .write_refused, .rdata, .req);

    // Variant copy on the same bus, so its own reset value of the pin and limit register shows in rdata_b
    pscr_top #(.HYS200_VARIANT(1'b1)) uut_hys (.core_clk, .resetn, .req, .gpo_level, .switch_enable,
        .power_fail_out_n, .shared_pin_in, .shared_pin_out(), .shared_pin_oe_n(), .buck_warm_reset(),
        .rdata(rdata_b), .rvalid(), .write_refused(), .lockout_hysteresis_select(hys_b),
        .switch3_current_limit(), .switch2_current_limit(), .switch_on(), .discharge_active(),
        .pulse_skip_enable(), .buck_one_vcode(), .buck_one_mv());

    // 100 ns period
    always #50 core_clk = ~core_clk;

    // Expected millivolts: fine steps up to the knee, coarse steps above
    function automatic logic [10:0] mv_of(input logic [5:0] c);
        if (c <= 6'h32) begin
            return 11'h352 + 11'(c) * 11'h00a;
        end
        return 11'h546 + 11'(c - 6'h32) * 11'h019;
    endfunction : mv_of

    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_rd(input logic [7:0] ad, input logic [7:0] exp);
        host.read(ad, rd, ok);
        chk("rvalid", 1'b1, ok);
        chk("rdata", exp, rd);
    endtask : chk_rd

    // Reset, then every register and the unmapped slot read back
    task automatic do_reset();
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        sh = '{8'hc0, 8'h00, 8'h99, 8'h00};
        for (int j = 0; j < 4; j++) begin
            chk_rd(8'h14 + 8'(j), sh[j]);
            if (j == 0) begin
                chk("rdata_hys200", 8'h80, rdata_b);
            end
        end
        chk("hyst200", 1'b0, hys_b);
        chk("buck_one_mv", 11'h44c, buck_one_mv);
    endtask : do_reset

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // Run is about 2500 cycles; cut a hang well past that
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        stop_test();
    end

    initial begin
        seed = 80541;
        fails = 0;
        compares = 0;
        do_reset();
        // Every voltage code, both sides of the knee included
        for (i = 0; i < 64; i++) begin
            host.write(8'h16, 8'(i), 1'b1, rf);
            repeat (2) @(posedge core_clk);
            #1;
            chk("buck_one_mv", mv_of(6'(i)), buck_one_mv);
        end
        sh[2] = 8'h3f;
        // Random writes, some locked, some unmapped, with pin traffic after each
        for (i = 0; i < 200; i++) begin
            r = $random(seed);
            a = 8'h14 + {6'h00, r[1:0]};
            u = r[16] | r[17];
            host.write(a, r[15:8], u, rf);
            chk("write_refused", !u, rf);
            if (u) begin
                sh[a[1:0]] = r[15:8] & msk[a[1:0]];
            end
            chk_rd(a, sh[a[1:0]]);
            chk("ilim3", sh[0][3:2], switch3_current_limit);
            chk("ilim2", sh[0][1:0], switch2_current_limit);
            chk("hyst", sh[0][6], lockout_hysteresis_select);
            chk("pulse_skip", sh[2][7], pulse_skip_enable);
            chk("vcode", sh[2][5:0], buck_one_vcode);
            chk("buck_one_mv", mv_of(sh[2][5:0]), buck_one_mv);
            r = $random(seed);
            @(posedge core_clk);
            gpo_level <= r[0];
            switch_enable <= r[3:1];
            power_fail_out_n <= r[4];
            shared_pin_in <= r[5];
            // Synchroniser plus output flop plus discharge stage
            repeat (6) @(posedge core_clk);
            #1;
            on = switch_enable & ~(sh[1][5:3] & {3{~power_fail_out_n}});
            chk("oe_n", sh[0][7] | gpo_level, shared_pin_oe_n);
            chk("pin_out", 1'b0, shared_pin_out);
            chk("warm_reset", sh[0][7] & ~shared_pin_in, buck_warm_reset);
            chk("switch_on", on, switch_on);
            chk("discharge", sh[1][2:0] & ~on, discharge_active);
        end
        do_reset();
        stop_test();
    end
endmodule : test_pmic_switch_buck_config_regs
`default_nettype wire
